// File: src/epm_pkg.sv
// Constants for the serial memory pin multiplexer and reset strap block.
// Assumes a 200 MHz core clock; used only by the top level, not by its helpers.
package epm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned POR_TIME_NS      = 1000;
  localparam int unsigned POR_CYCLES       = (POR_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned POR_CNT_W        = 12;
  localparam int unsigned SYNC_STAGES      = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles, shared by both multiplexed pins
  localparam logic [1:0] ROLE_SERIAL_MEM   = 2'h0;
  localparam logic [1:0] ROLE_GEN_OUTPUT   = 2'h1;
  localparam logic [1:0] ROLE_MON_FRAME    = 2'h2;  // TX_EN or RX_DV
  localparam logic [1:0] ROLE_MON_CLOCK    = 2'h3;  // TX_CLK or RX_CLK

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic       BUS_WIDTH_RESET   = 1'b0;  // 16-bit until strapped
  localparam logic       WRITE_LOCK_RESET  = 1'b1;
  localparam logic       CHIP_SEL_INACTIVE = 1'b0;

  // Reset sequencer, Gray coded along hold -> strap -> run
  typedef enum logic [1:0] {
    EPM_HOLD  = 2'b00,
    EPM_STRAP = 2'b01,
    EPM_RUN   = 2'b11
  } epm_state_e;

endpackage : epm_pkg

// File: src/epm_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or a clock sampled for monitoring only.
`timescale 1ns/100ps
module epm_sync #(
  parameter int unsigned WIDTH     = 1,
  parameter logic        RESET_VAL = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= {WIDTH{RESET_VAL}};
      sync_ff <= {WIDTH{RESET_VAL}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : epm_sync

// File: src/epm_top.sv
// Serial memory pin multiplexer, bus width strap, reset and write lock.
// Assumes pins and internal MII signals arrive asynchronously; the serial
// memory engine and host decode run on clk_i.
//
// Notes on behaviour
// - In memory role, data pin is bidirectional; clock and chip select are outputs.
// - Data pin may be general output three, or monitor TX_EN or TX_CLK.
// - Data pin in output or monitor role forces chip select inactive.
// - Clock pin may be general output four, or monitor RX_DV or RX_CLK.
// - Clock pin in output or monitor role forces chip select inactive.
// - General outputs on these pins never act as inputs.
// - Data pin sampled at reset release; high selects 32-bit bus, low 16-bit.
// - Low reset pin returns all logic and registers, except the input synchronisers, to reset state.
// - Without external reset, internal power-on reset generator resets device.
// - Host writes ignored after reset or power saving until one read completes.
// - Timing reference is a 25 MHz crystal or single-ended oscillator.
// - In power saving, wake only on host select plus write strobe.
`timescale 1ns/100ps
module epm_top #(
  parameter int unsigned POR_CYCLES = epm_pkg::POR_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Board pins
  input  wire logic       reset_in_n_i,
  input  wire logic       crystal_in_i,
  output logic            crystal_out_o,
  input  wire logic       serial_mem_data_io_i,
  output logic            serial_mem_data_io_o,
  output logic            serial_mem_data_io_oe_o,
  output logic            serial_mem_clock_o,
  output logic            serial_mem_chip_select_o,
  input  wire logic       host_select_n_i,
  input  wire logic       host_write_strobe_n_i,
  // Configuration
  input  wire logic [1:0] data_pin_role_i,
  input  wire logic [1:0] clock_pin_role_i,
  input  wire logic       general_output_three_i,
  input  wire logic       general_output_four_i,
  // Internal MII signals to monitor
  input  wire logic       mii_tx_en_i,
  input  wire logic       mii_tx_clk_i,
  input  wire logic       mii_rx_dv_i,
  input  wire logic       mii_rx_clk_i,
  // Serial memory engine side
  input  wire logic       mem_chip_select_i,
  input  wire logic       mem_clock_i,
  input  wire logic       mem_data_out_i,
  input  wire logic       mem_data_drive_i,
  output logic            mem_data_in_o,
  // Host access events, decoded on clk_i
  input  wire logic       host_read_done_i,
  input  wire logic       power_save_i,
  // Status
  output logic            chip_reset_o,
  output logic            bus_width_32_o,
  output logic            host_write_enable_o,
  output logic            wake_o,
  output logic            ref_tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything that crosses in from outside clk_i
  logic [7:0] async_lvl;
  logic [7:0] sync_lvl;
  logic       reset_in_n_sync;

  assign async_lvl = {host_write_strobe_n_i, host_select_n_i, crystal_in_i,
                      serial_mem_data_io_i, mii_rx_clk_i, mii_rx_dv_i,
                      mii_tx_clk_i, mii_tx_en_i};

  epm_sync #(
    .WIDTH     (8),
    .RESET_VAL (1'b0)
  ) u_sync_lvl (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (async_lvl),
    .sync_o  (sync_lvl)
  );

  // Reset pin idles high, so its synchroniser resets to released
  epm_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_sync_rst (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (reset_in_n_i),
    .sync_o  (reset_in_n_sync)
  );

  wire tx_en_s   = sync_lvl[0];
  wire tx_clk_s  = sync_lvl[1];
  wire rx_dv_s   = sync_lvl[2];
  wire rx_clk_s  = sync_lvl[3];
  wire data_in_s = sync_lvl[4];
  wire xtal_s    = sync_lvl[5];
  wire sel_n_s   = sync_lvl[6];
  wire wr_n_s    = sync_lvl[7];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer: power-on hold, strap sample, run
  epm_pkg::epm_state_e state_ff;
  epm_pkg::epm_state_e nxt_state;
  logic [epm_pkg::POR_CNT_W-1:0] por_cnt_ff;
  logic [epm_pkg::POR_CNT_W-1:0] nxt_por_cnt;

  // Pin reset and power-up reset both restart the whole sequence
  wire any_reset = reset_i | ~reset_in_n_sync;
  wire por_done  = (por_cnt_ff == POR_CYCLES[epm_pkg::POR_CNT_W-1:0] - 1'b1);

  // Next state and hold counter
  always_comb begin
    nxt_state   = state_ff;
    nxt_por_cnt = por_cnt_ff;
    case (state_ff)
      epm_pkg::EPM_HOLD: begin
        nxt_por_cnt = por_cnt_ff + 1'b1;
        if (por_done) begin
          nxt_state = epm_pkg::EPM_STRAP;
        end
      end
      epm_pkg::EPM_STRAP: begin
        nxt_state = epm_pkg::EPM_RUN;
      end
      epm_pkg::EPM_RUN: begin
        nxt_state = epm_pkg::EPM_RUN;
      end
      default: begin
        nxt_state = epm_pkg::EPM_HOLD;
      end
    endcase
  end

  // Internal power-on hold keeps chip in reset after any reset source
  always_ff @(posedge clk_i) begin
    if (any_reset) begin
      state_ff   <= epm_pkg::EPM_HOLD;
      por_cnt_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      por_cnt_ff <= nxt_por_cnt;
    end
  end

  wire running = (state_ff == epm_pkg::EPM_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Bus width strap, taken once as reset releases
  logic bus_width_ff;

  // Data pin is undriven outside run, so the strap level is what we see
  always_ff @(posedge clk_i) begin
    if (any_reset) begin
      bus_width_ff <= epm_pkg::BUS_WIDTH_RESET;
    end else if (state_ff == epm_pkg::EPM_STRAP) begin
      bus_width_ff <= data_in_s;
    end
  end
  // No other load path: later pin activity cannot disturb it

  ////////////////////////////////////////////////////////////////////////////
  // Pin role selection
  wire data_mem  = (data_pin_role_i == epm_pkg::ROLE_SERIAL_MEM);
  wire clock_mem = (clock_pin_role_i == epm_pkg::ROLE_SERIAL_MEM);

  logic data_sel;
  logic clock_sel;

  // Data pin source per role
  always_comb begin
    case (data_pin_role_i)
      epm_pkg::ROLE_SERIAL_MEM: data_sel = mem_data_out_i;
      epm_pkg::ROLE_GEN_OUTPUT: data_sel = general_output_three_i;
      epm_pkg::ROLE_MON_FRAME:  data_sel = tx_en_s;
      epm_pkg::ROLE_MON_CLOCK:  data_sel = tx_clk_s;
      default:                  data_sel = 1'b0;
    endcase
  end

  // Clock pin source per role
  always_comb begin
    case (clock_pin_role_i)
      epm_pkg::ROLE_SERIAL_MEM: clock_sel = mem_clock_i;
      epm_pkg::ROLE_GEN_OUTPUT: clock_sel = general_output_four_i;
      epm_pkg::ROLE_MON_FRAME:  clock_sel = rx_dv_s;
      epm_pkg::ROLE_MON_CLOCK:  clock_sel = rx_clk_s;
      default:                  clock_sel = 1'b0;
    endcase
  end

  // Non-memory roles drive whenever running: they never turn the pin round
  wire data_oe   = running & (data_mem ? mem_data_drive_i : 1'b1);
  // Chip select only when both pins serve the memory
  wire chip_sel  = running & data_mem & clock_mem & mem_chip_select_i;

  logic data_out_ff;
  logic data_oe_ff;
  logic clock_out_ff;
  logic chip_sel_ff;
  logic mem_data_in_ff;

  // Registered pin drivers; quiet during reset so the strap can be read
  always_ff @(posedge clk_i) begin
    if (any_reset) begin
      data_out_ff    <= 1'b0;
      data_oe_ff     <= 1'b0;
      clock_out_ff   <= 1'b0;
      chip_sel_ff    <= epm_pkg::CHIP_SEL_INACTIVE;
      mem_data_in_ff <= 1'b0;
    end else begin
      data_out_ff    <= data_sel;
      data_oe_ff     <= data_oe;
      clock_out_ff   <= running & clock_sel;
      chip_sel_ff    <= chip_sel;
      mem_data_in_ff <= data_mem & ~mem_data_drive_i & data_in_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock: inverted crystal return and one tick per cycle
  logic xtal_prev_ff;
  logic xtal_out_ff;
  logic ref_tick_ff;

  // Tick width is one core cycle; useful only as a presence indicator
  always_ff @(posedge clk_i) begin
    if (any_reset) begin
      xtal_prev_ff <= 1'b0;
      xtal_out_ff  <= 1'b1;
      ref_tick_ff  <= 1'b0;
    end else begin
      xtal_prev_ff <= xtal_s;
      xtal_out_ff  <= ~xtal_s;
      ref_tick_ff  <= xtal_s & ~xtal_prev_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write lock until first read, and wake from power saving
  logic write_lock_ff;
  logic power_save_ff;
  logic wake_ff;

  wire host_write_seen = ~sel_n_s & ~wr_n_s;
  wire ps_change       = power_save_i ^ power_save_ff;

  // Entering or leaving power saving relocks; relock wins over a read
  always_ff @(posedge clk_i) begin
    if (any_reset) begin
      write_lock_ff <= epm_pkg::WRITE_LOCK_RESET;
      power_save_ff <= 1'b0;
      wake_ff       <= 1'b0;
    end else begin
      power_save_ff <= power_save_i;
      wake_ff       <= running & power_save_i & host_write_seen;
      if (ps_change) begin
        write_lock_ff <= 1'b1;
      end else if (host_read_done_i & ~power_save_i & running) begin
        write_lock_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign serial_mem_data_io_o     = data_out_ff;
  assign serial_mem_data_io_oe_o  = data_oe_ff;
  assign serial_mem_clock_o       = clock_out_ff;
  assign serial_mem_chip_select_o = chip_sel_ff;
  assign mem_data_in_o            = mem_data_in_ff;
  assign crystal_out_o            = xtal_out_ff;
  assign ref_tick_o               = ref_tick_ff;
  assign chip_reset_o             = ~running;
  assign bus_width_32_o           = bus_width_ff;
  assign host_write_enable_o      = ~write_lock_ff;
  assign wake_o                   = wake_ff;

endmodule : epm_top

// File: test/epm_chk.sv
// Assertion checker for the serial memory pin multiplexer top level.
// Assumes it is bound to epm_top; role 0 memory, 1 output, 2 frame monitor.
`timescale 1ns/100ps
module epm_chk (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       crystal_in_i,
  input wire logic [1:0] data_pin_role_i,
  input wire logic [1:0] clock_pin_role_i,
  input wire logic       general_output_three_i,
  input wire logic       mii_tx_en_i,
  input wire logic       mem_chip_select_i,
  input wire logic       host_read_done_i,
  input wire logic       power_save_i,
  input wire logic       serial_mem_data_io_o,
  input wire logic       serial_mem_data_io_oe_o,
  input wire logic       serial_mem_chip_select_o,
  input wire logic       crystal_out_o,
  input wire logic       chip_reset_o,
  input wire logic       bus_width_32_o,
  input wire logic       host_write_enable_o,
  input wire logic       wake_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////
  // Pin-reset path raises chip_reset_o, which excuses the pin checks
  a_cs_mem_only: assert property (
    serial_mem_chip_select_o |-> $past(mem_chip_select_i) && $past(data_pin_role_i) == 2'h0
    && $past(clock_pin_role_i) == 2'h0) else $error("chip select outside memory role");
  a_gen_out_follow: assert property (
    !chip_reset_o && data_pin_role_i == 2'h1 |=> chip_reset_o
    || serial_mem_data_io_oe_o && serial_mem_data_io_o == $past(general_output_three_i))
    else $error("data pin not a general output");
  // Two sync stages plus the output register
  a_tx_en_mon: assert property (
    (!chip_reset_o && data_pin_role_i == 2'h2) [*4]
    |-> serial_mem_data_io_o == $past(mii_tx_en_i, 3)) else $error("frame monitor wrong");
  a_reset_quiet: assert property (
    chip_reset_o |-> !serial_mem_chip_select_o && !serial_mem_data_io_oe_o
    && !host_write_enable_o) else $error("outputs active in reset");
  a_width_hold: assert property (
    !chip_reset_o && !$past(chip_reset_o) |-> $stable(bus_width_32_o))
    else $error("bus width moved");
  a_read_unlocks: assert property (
    host_read_done_i && !chip_reset_o && !power_save_i && $stable(power_save_i)
    |=> chip_reset_o || host_write_enable_o) else $error("read left writes locked");
  a_save_relocks: assert property (
    $changed(power_save_i) |=> !host_write_enable_o) else $error("writes open after mode change");
  a_wake_cause: assert property (
    wake_o |-> $past(power_save_i) && !$past(chip_reset_o)) else $error("wake without sleep");
  // Crystal return is the synced input inverted: two sync stages plus a register
  a_ref_return: assert property (
    !chip_reset_o |-> crystal_out_o == !$past(crystal_in_i, 3))
    else $error("crystal return wrong");
endmodule : epm_chk
bind epm_top epm_chk epm_chk_inst (.*);

// File: test/epm_mem_model.sv
// Behavioural serial memory on the far side of the multiplexed pins.
// Assumes the bench resolves the shared data line from all drivers.
`timescale 1ns/100ps
module epm_mem_model (
  input  wire logic chip_select_i,
  input  wire logic clock_i,
  input  wire logic data_i,
  input  wire logic dev_drive_i,
  output logic      drive_o,
  output logic      data_o
);
  logic last_ff;
  // Keep the last bit shifted in while selected and the device drives
  always_ff @(posedge clock_i) begin
    if (chip_select_i && dev_drive_i) begin
      last_ff <= data_i;
    end
  end
  // Answer inverted, so a stale line never looks right
  assign drive_o = chip_select_i && !dev_drive_i;
  assign data_o  = ~last_ff;
endmodule : epm_mem_model

// File: test/testbench.sv
// Self-checking bench for the serial memory pin multiplexer and strap.
// Assumes a short power-on hold and a memory model on the shared pins.
`timescale 1ns/100ps
module testbench;
  localparam int unsigned POR  = 4;
  // Two passes, so every source of a pin shows a pattern of its own
  localparam logic [7:0]  DEXP = 8'hC6;  // Per pass and role: output three, TX_EN, TX_CLK
  localparam logic [7:0]  CEXP = 8'hCA;  // Per pass and role: output four, RX_DV, RX_CLK
  logic       clk_i = 1'b0, reset_i = 1'b1, rst_n = 1'b1, xtal = 1'b0, pull = 1'b1;
  logic       sel_n = 1'b1, wr_n = 1'b1, g3 = 1'b1, m_cs = 1'b1, m_clk = 1'b0;
  logic       m_do = 1'b0, m_drv = 1'b0, rd = 1'b0, ps = 1'b0;
  logic [1:0] drole = 2'h0, crole = 2'h0;
  logic [3:0] mii = 4'h9;  // RX_CLK, RX_DV, TX_CLK, TX_EN
  logic       g4 = 1'b1;
  logic       d_o, d_oe, sclk, cs, m_di, crst, w32, wen, wake, tick, md_en, md, pin;
  int         errors = 0, check_count = 0, cycles = 0, ticks = 0, t0;
  ////////////////////////////////////////////////////////////////////////////
  // Data line: device, then memory, else the strap resistor
  assign pin = d_oe ? d_o : (md_en ? md : pull);
  initial forever #2.5 clk_i = ~clk_i;
  // 25 MHz reference, phase unrelated to the core clock
  initial begin
    #1.2;
    forever #20 xtal = ~xtal;
  end
  epm_top #(.POR_CYCLES(POR)) epm_top_inst (
    .clk_i(clk_i), .reset_i(reset_i), .reset_in_n_i(rst_n), .crystal_in_i(xtal),
    .crystal_out_o(), .serial_mem_data_io_i(pin), .serial_mem_data_io_o(d_o),
    .serial_mem_data_io_oe_o(d_oe), .serial_mem_clock_o(sclk), .serial_mem_chip_select_o(cs),
    .host_select_n_i(sel_n), .host_write_strobe_n_i(wr_n), .data_pin_role_i(drole),
    .clock_pin_role_i(crole), .general_output_three_i(g3), .general_output_four_i(g4),
    .mii_tx_en_i(mii[0]), .mii_tx_clk_i(mii[1]), .mii_rx_dv_i(mii[2]), .mii_rx_clk_i(mii[3]),
    .mem_chip_select_i(m_cs), .mem_clock_i(m_clk), .mem_data_out_i(m_do),
    .mem_data_drive_i(m_drv), .mem_data_in_o(m_di), .host_read_done_i(rd),
    .power_save_i(ps), .chip_reset_o(crst), .bus_width_32_o(w32),
    .host_write_enable_o(wen), .wake_o(wake), .ref_tick_o(tick));
  epm_mem_model epm_mem_model_inst (.chip_select_i(cs), .clock_i(sclk), .data_i(pin),
    .dev_drive_i(d_oe), .drive_o(md_en), .data_o(md));
  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // Hang guard, well above the roughly 170 cycles of the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    ticks  <= ticks + int'(tick === 1'b1);
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    cyc(6);
    reset_i <= 1'b0;
    cyc(POR + 3);
    #1;
    chk("chip reset", 1'b0, crst);
    chk("bus width", 1'b1, w32);
    chk("write enable", 1'b0, wen);
    @(posedge clk_i);
    drole <= 2'h1;
    g3    <= 1'b0;
    cyc(2);
    #1;
    chk("data pin", 1'b0, d_o);
    chk("bus width", 1'b1, w32);
    // Every non-memory role on both pins, engine asking for select
    for (int p = 0; p < 2; p++) begin
      for (int r = 1; r < 4; r++) begin
        @(posedge clk_i);
        g3    <= (p == 0);
        g4    <= (p == 0);
        mii   <= (p == 0) ? 4'h9 : 4'hF;
        drole <= 2'(r);
        crole <= 2'(r);
        cyc(4);
        #1;
        chk("data pin", DEXP[4*p+r], d_o);
        chk("clock pin", CEXP[4*p+r], sclk);
        chk("chip select", 1'b0, cs);
        chk("data drive", 1'b1, d_oe);
      end
    end
    @(posedge clk_i);
    drole <= 2'h0;
    cyc(1);
    #1;
    chk("chip select", 1'b0, cs);
    @(posedge clk_i);
    crole <= 2'h0;
    m_drv <= 1'b1;
    m_do  <= 1'b1;
    // Clock rises a cycle later, so the memory samples settled select and data
    @(posedge clk_i);
    m_clk <= 1'b1;
    cyc(1);
    #1;
    chk("chip select", 1'b1, cs);
    chk("data pin", 1'b1, d_o);
    chk("memory clock", 1'b1, sclk);
    @(posedge clk_i);
    m_clk <= 1'b0;
    m_drv <= 1'b0;
    cyc(4);
    #1;
    chk("data drive", 1'b0, d_oe);
    chk("data in", 1'b0, m_di);
    @(posedge clk_i);
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk("write enable", 1'b1, wen);
    @(posedge clk_i);
    ps <= 1'b1;
    cyc(2);
    // A read while sleeping must not unlock; select alone must not wake
    @(posedge clk_i);
    rd    <= 1'b1;
    sel_n <= 1'b0;
    @(posedge clk_i);
    rd <= 1'b0;
    cyc(3);
    #1;
    chk("write enable", 1'b0, wen);
    chk("wake", 1'b0, wake);
    @(posedge clk_i);
    wr_n <= 1'b0;
    cyc(3);
    #1;
    chk("wake", 1'b1, wake);
    @(posedge clk_i);
    sel_n <= 1'b1;
    wr_n  <= 1'b1;
    ps    <= 1'b0;
    t0 = ticks;
    cyc(80);
    check_count++;
    if (ticks - t0 != 10) begin
      errors++;
      $display("[FAIL] reference ticks expected 10 seen %0d", ticks - t0);
    end
    @(posedge clk_i);
    pull  <= 1'b0;
    rst_n <= 1'b0;
    cyc(3);
    #1;
    chk("chip reset", 1'b1, crst);
    chk("write enable", 1'b0, wen);
    @(posedge clk_i);
    rst_n <= 1'b1;
    cyc(POR + 6);
    #1;
    chk("chip reset", 1'b0, crst);
    chk("bus width", 1'b0, w32);
    chk("write enable", 1'b0, wen);
    end_sim();
  end
endmodule : testbench
